// ==== pkg/dac_cal_pkg.sv ====
// constants, layouts and carrier types for the dac user calibration engine
package dac_cal_pkg;
  // channel count and word width
  localparam int CHANNELS = 8;
  localparam int WORD_W = 16;
  // address regions, selected by byte address bits 7:5
  localparam logic [2:0] REGION_CTRL = 3'h0;
  localparam logic [2:0] REGION_INPUT = 3'h1;
  localparam logic [2:0] REGION_GAIN = 3'h2;
  localparam logic [2:0] REGION_ZERO = 3'h3;
  localparam logic [2:0] REGION_DAC = 3'h4;
  // control region words, selected by byte address bits 4:2
  localparam logic [2:0] CTRL_CONFIG = 3'h0;
  localparam logic [2:0] CTRL_STATUS = 3'h1;
  // field positions
  localparam int CONFIG_ENABLE_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_PEND_LSB = 8;
  // reset values
  localparam logic [15:0] GAIN_RESET = 16'h8000;
  localparam logic [15:0] ZERO_RESET = 16'h0000;
  localparam logic [15:0] INPUT_RESET = 16'h0000;
  localparam logic [15:0] DAC_RESET = 16'h0000;
  localparam logic ENABLE_RESET = 1'h0;
  // arithmetic constants: gain bias of 2^15, product scaled down by 2^16
  localparam logic [16:0] GAIN_BIAS = 17'h08000;
  localparam int PRODUCT_SHIFT = 16;
  localparam logic signed [18:0] WORD_MAX = 19'sh0FFFF;
  // engine sequence
  typedef enum logic [1:0] {ST_IDLE, ST_MULT, ST_STORE} engine_state_type;
  // decoded register access
  typedef struct packed {
    logic mapped;
    logic [2:0] region;
    logic [2:0] chan;
  } reg_sel_type;
  // four words of one channel group
  typedef logic [3:0][15:0] group_words_type;
  // notice of a new dac data word
  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [15:0] word;
  } dac_update_type;
endpackage

// ==== logic/dac_cal_engine.sv ====
// eight channel dac user calibration engine behind a classic wishbone slave
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// Contract
// - channels 0-3 group A, 4-7 group B
// - per channel zero, gain, input, dac registers
// - enabled: input times gain plus zero
// - enabled writes trigger correction into dac data
// - effective gain ranges one half to 1.5
// - zero adds signed -32768..+32767 offset
// - one shared engine serves channels in turn
// - config bit 0 off, 1 on
// - disabled: input written straight to dac
// - disabled: coefficient writes start nothing
// - disabled: coefficients read back as written
// - 16-bit straight binary word per latch
// - (in*(gain+2^15))/2^16 plus zero
// - reset: gain 32768, zero 0, input 0
// - gain unsigned, zero twos complement always
module dac_cal_engine (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // converter latch words and dac data update notice
  output dac_cal_pkg::group_words_type group_a_words_o,
  output dac_cal_pkg::group_words_type group_b_words_o,
  output dac_cal_pkg::dac_update_type dac_update_o
);

  // per channel registers
  logic [7:0][15:0] input_r; // input data words
  logic [7:0][15:0] gain_r; // unsigned gain codes
  logic [7:0][15:0] zero_r; // twos complement zero codes
  logic [7:0][15:0] dac_r; // dac data words
  // control and bus state
  logic correction_enable_bit; // correction on when high
  logic ack_r; // bus answer
  logic [31:0] rd_r; // captured read data
  logic [31:0] rd_nxt; // read data for the current address
  dac_cal_pkg::reg_sel_type dec; // decoded address
  logic wr_fire; // write takes effect this edge
  // engine state
  dac_cal_pkg::engine_state_type st_r;
  logic [2:0] chan_r; // channel in service
  logic [7:0] pend_r; // channels waiting for correction
  logic [7:0] pend_nxt;
  logic [7:0] pend_set; // new requests
  logic [7:0] pend_clr; // taken or superseded requests
  logic [2:0] pick; // lowest pending channel
  logic [32:0] prod_r; // input times biased gain
  logic [15:0] zero_hold_r; // zero code of the channel in service
  logic signed [18:0] sum; // scaled product plus zero
  logic [15:0] corr_word; // clamped result
  logic eng_store; // engine writes dac data this edge
  dac_cal_pkg::dac_update_type upd_r;

  // lowest set bit of a request mask
  function automatic logic [2:0] lowest(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // byte lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // address decode: only the low byte carries a register, upper bits must be zero
  always_comb begin
    dec.region = wb_adr_i[7:5];
    dec.chan = wb_adr_i[4:2];
    dec.mapped = (wb_adr_i[31:8] == 24'h000000) && (wb_adr_i[7:5] <= dac_cal_pkg::REGION_DAC);
    if (wb_adr_i[7:5] == dac_cal_pkg::REGION_CTRL) begin
      dec.mapped = dec.mapped && (wb_adr_i[4:3] == 2'h0);
    end
  end

  // a write lands on the edge that carries the answer
  assign wr_fire = ce_i && wb_cyc_i && wb_stb_i && wb_we_i && ack_r && dec.mapped;

  // answer one cycle after the request, drop it the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else if (ce_i) begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end
  end

  assign wb_ack_o = ack_r;

  // read mux; unmapped words read zero
  always_comb begin
    rd_nxt = 32'h00000000;
    if (dec.mapped) begin
      unique case (dec.region)
        dac_cal_pkg::REGION_CTRL: begin
          if (dec.chan == dac_cal_pkg::CTRL_CONFIG) begin
            rd_nxt[dac_cal_pkg::CONFIG_ENABLE_BIT] = correction_enable_bit;
          end else begin
            rd_nxt[dac_cal_pkg::STATUS_BUSY_BIT] = (st_r != dac_cal_pkg::ST_IDLE) || (|pend_r);
            rd_nxt[dac_cal_pkg::STATUS_PEND_LSB +: 8] = pend_r;
          end
        end
        dac_cal_pkg::REGION_INPUT: rd_nxt[15:0] = input_r[dec.chan];
        // coefficients read back exactly as stored
        dac_cal_pkg::REGION_GAIN: rd_nxt[15:0] = gain_r[dec.chan];
        dac_cal_pkg::REGION_ZERO: rd_nxt[15:0] = zero_r[dec.chan];
        dac_cal_pkg::REGION_DAC: rd_nxt[15:0] = dac_r[dec.chan];
        default: rd_nxt = 32'h00000000;
      endcase
    end
  end

  // capture read data when the request is first seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_r <= 32'h00000000;
    end else if (ce_i && wb_cyc_i && wb_stb_i && !ack_r) begin
      rd_r <= rd_nxt;
    end
  end

  assign wb_dat_o = rd_r;

  // configuration bit switches the engine off or on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      correction_enable_bit <= dac_cal_pkg::ENABLE_RESET;
    end else if (wr_fire && dec.region == dac_cal_pkg::REGION_CTRL &&
                 dec.chan == dac_cal_pkg::CTRL_CONFIG && wb_sel_i[0]) begin
      correction_enable_bit <= wb_dat_i[dac_cal_pkg::CONFIG_ENABLE_BIT];
    end
  end

  // request bookkeeping
  always_comb begin
    pick = lowest(pend_r);
    pend_set = 8'h00;
    pend_clr = 8'h00;
    // any input, gain or zero write queues a correction
    // nothing is queued while correction is off
    if (wr_fire && correction_enable_bit && dec.region >= dac_cal_pkg::REGION_INPUT &&
        dec.region <= dac_cal_pkg::REGION_ZERO) begin
      pend_set[dec.chan] = 1'b1;
    end
    if (ce_i && st_r == dac_cal_pkg::ST_IDLE && (|pend_r)) begin
      pend_clr[pick] = 1'b1;
    end
    // a direct copy supersedes a stale queued correction
    if (wr_fire && !correction_enable_bit && dec.region == dac_cal_pkg::REGION_INPUT) begin
      pend_clr[dec.chan] = 1'b1;
    end
    // a new request wins over a clear in the same cycle
    pend_nxt = (pend_r & ~pend_clr) | pend_set;
  end

  // pending request mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= 8'h00;
    end else if (ce_i) begin
      pend_r <= pend_nxt;
    end
  end

  // single engine, one channel at a time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= dac_cal_pkg::ST_IDLE;
      chan_r <= 3'h0;
      prod_r <= 33'h000000000;
      zero_hold_r <= 16'h0000;
    end else if (ce_i) begin
      unique case (st_r)
        dac_cal_pkg::ST_IDLE: begin
          if (|pend_r) begin
            chan_r <= pick;
            st_r <= dac_cal_pkg::ST_MULT;
          end
        end
        dac_cal_pkg::ST_MULT: begin
          // gain code plus 2^15 gives a factor of 0.5 to 1.5 after scaling
          prod_r <= 33'(input_r[chan_r]) * 33'({1'b0, gain_r[chan_r]} + dac_cal_pkg::GAIN_BIAS);
          zero_hold_r <= zero_r[chan_r];
          st_r <= dac_cal_pkg::ST_STORE;
        end
        dac_cal_pkg::ST_STORE: begin
          st_r <= dac_cal_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // scaled product plus signed zero, then clamp
  always_comb begin
    // drop the low 16 bits of the product
    // zero code is sign extended before the add
    sum = $signed({2'b00, prod_r[32:dac_cal_pkg::PRODUCT_SHIFT]}) +
          $signed({{3{zero_hold_r[15]}}, zero_hold_r});
    if (sum < 19'sh00000) begin
      corr_word = 16'h0000;
    end else if (sum > dac_cal_pkg::WORD_MAX) begin
      corr_word = 16'hFFFF;
    end else begin
      corr_word = sum[15:0];
    end
  end

  assign eng_store = ce_i && st_r == dac_cal_pkg::ST_STORE;

  for (genvar c = 0; c < dac_cal_pkg::CHANNELS; c++) begin : g_chan
    logic hit; // a write lands on this channel
    assign hit = wr_fire && dec.chan == 3'(c);

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        input_r[c] <= dac_cal_pkg::INPUT_RESET;
        gain_r[c] <= dac_cal_pkg::GAIN_RESET;
        zero_r[c] <= dac_cal_pkg::ZERO_RESET;
      end else if (hit) begin
        if (dec.region == dac_cal_pkg::REGION_INPUT) begin
          input_r[c] <= merge16(input_r[c], wb_dat_i, wb_sel_i);
        end
        if (dec.region == dac_cal_pkg::REGION_GAIN) begin
          gain_r[c] <= merge16(gain_r[c], wb_dat_i, wb_sel_i);
        end
        if (dec.region == dac_cal_pkg::REGION_ZERO) begin
          zero_r[c] <= merge16(zero_r[c], wb_dat_i, wb_sel_i);
        end
      end
    end

    // dac data: engine result, or a straight copy when correction is off
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        dac_r[c] <= dac_cal_pkg::DAC_RESET;
      end else if (eng_store && chan_r == 3'(c)) begin
        // corrected word lands in dac data
        dac_r[c] <= corr_word;
      end else if (hit && !correction_enable_bit && dec.region == dac_cal_pkg::REGION_INPUT) begin
        dac_r[c] <= merge16(dac_r[c], wb_dat_i, wb_sel_i);
      end
    end
  end

  // one-cycle notice of a dac data update, the engine store winning over a same-cycle direct copy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd_r <= '0;
    end else if (ce_i) begin
      upd_r.valid <= eng_store ||
                     (wr_fire && !correction_enable_bit && dec.region == dac_cal_pkg::REGION_INPUT);
      upd_r.chan <= eng_store ? chan_r : dec.chan;
      upd_r.word <= eng_store ? corr_word : merge16(dac_r[dec.chan], wb_dat_i, wb_sel_i);
    end
  end

  assign dac_update_o = upd_r;
  // two groups of four latch words
  assign group_a_words_o = dac_r[3:0];
  assign group_b_words_o = dac_r[7:4];

  // reference result, formed independently for checking
  logic signed [19:0] ref_sum;
  logic [15:0] ref_word;
  always_comb begin
    ref_sum = 20'sd0 + $signed({3'b000, 17'((34'(input_r[chan_r]) *
              (34'(gain_r[chan_r]) + 34'd32768)) >> 16)}) + 20'(signed'(zero_r[chan_r]));
    ref_word = (ref_sum < 0) ? 16'h0000 : (ref_sum > 20'sd65535) ? 16'hFFFF : ref_sum[15:0];
  end

  a_reset_values: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |-> gain_r[5] == 16'h8000 && zero_r[2] == 16'h0000 &&
    input_r[7] == 16'h0000)
    else $error("coefficients not at reset values");
  a_corr_value: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r == dac_cal_pkg::ST_MULT && ce_i && !wr_fire) ##1 ce_i |=>
    dac_r[$past(chan_r, 2)] == $past(ref_word, 2))
    else $error("corrected word wrong");
  a_clamp_low: assert property (@(posedge clk_i) disable iff (rst_i)
    eng_store && sum < 0 |=> dac_r[$past(chan_r)] == 16'h0000)
    else $error("negative result not clamped");
  a_direct_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_fire && !correction_enable_bit && dec.region == dac_cal_pkg::REGION_INPUT &&
    wb_sel_i[1:0] == 2'b11 && !eng_store |=> dac_r[$past(dec.chan)] == $past(wb_dat_i[15:0]))
    else $error("direct copy missing");
  a_no_queue_off: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_fire && !correction_enable_bit |=> (pend_r & ~$past(pend_r)) == 8'h00)
    else $error("correction queued while disabled");
  a_queue_on: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_fire && correction_enable_bit && dec.region == dac_cal_pkg::REGION_GAIN |=>
    pend_r[$past(dec.chan)])
    else $error("write did not queue correction");
  a_serve_pending: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r == dac_cal_pkg::ST_IDLE && (|pend_r) && ce_i |=>
    st_r == dac_cal_pkg::ST_MULT ##1 (st_r == dac_cal_pkg::ST_STORE || !$past(ce_i)))
    else $error("pending request not served");
  a_coeff_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_r && !wb_we_i && $past(wb_cyc_i && wb_stb_i && dec.region == dac_cal_pkg::REGION_GAIN &&
    dec.mapped && ce_i) |-> wb_dat_o == {16'h0000, gain_r[$past(dec.chan)]})
    else $error("gain read back wrong");
  a_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_fire && dec.region == dac_cal_pkg::REGION_CTRL && dec.chan == dac_cal_pkg::CTRL_CONFIG &&
    wb_sel_i[0] |=> correction_enable_bit == $past(wb_dat_i[0]))
    else $error("enable bit not written");

endmodule

// ==== testbench/host_model.sv ====
// wishbone host model that issues single classic cycles for the bench
`timescale 1ns/1ps
module host_model (
  // clock and answer
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  // request lines
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [31:0] adr_o,
  output logic [31:0] dat_o,
  output logic [3:0] sel_o
);
  // idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 32'hFFFFFFFF;
    dat_o = 32'h00000000;
    sel_o = 4'h0;
  end
  // one cycle: raise, hold until ack, release; we, address and data then show inverted values
  task automatic xfer(input logic we, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output bit ok);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= a;
    dat_o <= d;
    sel_o <= 4'h3;
    ok = 0;
    q = 32'h00000000;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) begin
        ok = 1;
        q = dat_i;
      end
    end
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= ~we;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule

// ==== testbench/dac_user_calibration_engine_tb_top.sv ====
// self-checking bench for the calibration engine over wishbone
`timescale 1ns/1ps
module dac_user_calibration_engine_tb_top;
  logic clk_i = 1'b0; // 40 MHz clock
  logic rst_i = 1'b1; // synchronous reset
  logic ce_i = 1'b1; // clock enable, on except during the clock enable test
  logic cyc, stb, we, ack; // bus handshake
  logic [31:0] adr, wdat, rdat; // bus address and data
  logic [3:0] sel; // byte lanes
  dac_cal_pkg::group_words_type wa, wb; // latch words
  dac_cal_pkg::dac_update_type upd; // update notice
  int miscompares = 0;
  int tests_run = 0;
  logic [15:0] gm [8]; // expected gain codes
  logic [15:0] zm [8]; // expected zero codes
  logic [15:0] tv [4][3]; // input, gain, zero cases
  logic [31:0] q; // last read word
  logic [2:0] upd_chan = 3'h0; // channel of the last update notice
  logic [15:0] upd_word = 16'h0000; // word of the last update notice
  int upd_cnt = 0; // update notices seen so far
  int upd_base; // notice count at the start of a test
  // update notice monitor, sampled at the edge that ends the pulse
  always @(posedge clk_i) begin
    if (upd.valid === 1'b1) begin
      upd_chan <= upd.chan;
      upd_word <= upd.word;
      upd_cnt <= upd_cnt + 1;
    end
  end
  // clock
  always #12.5 clk_i = ~clk_i;
  dac_cal_engine dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .group_a_words_o(wa), .group_b_words_o(wb),
    .dac_update_o(upd));
  host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .dat_o(wdat), .sel_o(sel));
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // compare one 16 bit word
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // compare the last update notice, channel and word
  task automatic chk_upd(input logic [2:0] ch, input logic [15:0] exp);
    tests_run++;
    if (upd_chan !== ch || upd_word !== exp) begin
      miscompares++;
      $display("[ERR] %0t notice ch %0d word %h expected ch %0d word %h", $time,
               upd_chan, upd_word, ch, exp);
    end
  endtask
  // bus access with timeout
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    bit ok;
    host.xfer(w, a, d, q, ok);
    if (!ok) begin
      miscompares++;
      $display("[ERR] %0t no bus answer", $time);
      tally_and_finish();
    end
  endtask
  // expected corrected word, clamped
  function automatic logic [15:0] calc(input logic [15:0] i, input logic [15:0] g,
                                        input logic [15:0] z);
    longint p;
    p = (longint'(i) * (longint'(g) + 32768)) >>> 16;
    p = p + longint'($signed(z));
    if (p < 0) p = 0;
    if (p > 65535) p = 65535;
    return p[15:0];
  endfunction
  // poll status until engine idle and queue empty
  task automatic wait_idle();
    int n;
    for (n = 0; n < 40; n++) begin
      acc(1'b0, 32'h04, 32'h0);
      if (q[0] === 1'b0 && q[15:8] === 8'h00) return;
    end
    miscompares++;
    $display("[ERR] %0t engine never idle", $time);
    tally_and_finish();
  endtask
  // check latch word of channel n
  task automatic chk_lat(input int n, input logic [15:0] exp);
    if (n < 4) chk(wa[n], exp); else chk(wb[n-4], exp);
  endtask
  initial begin
    tv = '{'{16'h8000, 16'h0000, 16'h0000}, '{16'hFFFF, 16'hFFFF, 16'h0000},
           '{16'h1000, 16'h8000, 16'h8000}, '{16'h4000, 16'h8000, 16'h7FFF}};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values of every channel register and the config word
    for (int n = 0; n < 8; n++) begin
      gm[n] = 16'h8000;
      zm[n] = 16'h0000;
      acc(1'b0, 32'h40 + 4 * n, 0); chk(q[15:0], 16'h8000);
      acc(1'b0, 32'h60 + 4 * n, 0); chk(q[15:0], 16'h0000);
      acc(1'b0, 32'h20 + 4 * n, 0); chk(q[15:0], 16'h0000);
      chk_lat(n, 16'h0000);
    end
    acc(1'b0, 32'h00, 0); chk(q[15:0], 16'h0000);
    $display("test reset values done");
    // disabled: coefficients read back, no calculation, direct copy
    acc(1'b1, 32'h4C, 32'h1234); gm[3] = 16'h1234;
    acc(1'b1, 32'h6C, 32'hFEDC); zm[3] = 16'hFEDC;
    acc(1'b0, 32'h04, 0); chk(q[15:0], 16'h0000);
    acc(1'b0, 32'h4C, 0); chk(q[15:0], 16'h1234);
    acc(1'b0, 32'h6C, 0); chk(q[15:0], 16'hFEDC);
    chk_lat(3, 16'h0000);
    acc(1'b1, 32'h34, 32'hA5C3);
    acc(1'b0, 32'h94, 0); chk(q[15:0], 16'hA5C3);
    chk_lat(5, 16'hA5C3);
    chk_upd(3'h5, 16'hA5C3);
    $display("test bypass done");
    // enabled: gain extremes, signed zero, clamping
    acc(1'b1, 32'h00, 32'h1);
    for (int n = 0; n < 4; n++) begin
      acc(1'b1, 32'h40 + 4 * n, tv[n][1]); gm[n] = tv[n][1];
      acc(1'b1, 32'h60 + 4 * n, tv[n][2]); zm[n] = tv[n][2];
      acc(1'b1, 32'h20 + 4 * n, tv[n][0]);
      wait_idle();
      acc(1'b0, 32'h80 + 4 * n, 0);
      chk(q[15:0], calc(tv[n][0], gm[n], zm[n]));
    end
    $display("test arithmetic done");
    // back to back inputs on all channels share the one engine
    upd_base = upd_cnt;
    for (int n = 0; n < 8; n++) acc(1'b1, 32'h20 + 4 * n, 16'h0100 * (n + 1));
    wait_idle();
    chk(16'(upd_cnt - upd_base), 16'h0008);
    for (int n = 0; n < 8; n++) chk_lat(n, calc(16'h0100 * (n + 1), gm[n], zm[n]));
    $display("test shared engine done");
    // a coefficient write alone recomputes the channel
    acc(1'b1, 32'h7C, 32'h0010); zm[7] = 16'h0010;
    wait_idle();
    chk_lat(7, calc(16'h0800, gm[7], zm[7]));
    acc(1'b1, 32'h58, 32'hC000); gm[6] = 16'hC000;
    wait_idle();
    chk_lat(6, calc(16'h0700, gm[6], zm[6]));
    $display("test coefficient retrigger done");
    // a low clock enable holds a queued correction until it rises again
    acc(1'b1, 32'h20, 32'h2000);
    ce_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk_lat(0, calc(16'h0100, gm[0], zm[0]));
    ce_i <= 1'b1;
    wait_idle();
    chk_lat(0, calc(16'h2000, gm[0], zm[0]));
    chk_upd(3'h0, calc(16'h2000, gm[0], zm[0]));
    // dac data words are read only over the bus
    acc(1'b1, 32'h80, 32'hBEEF);
    acc(1'b0, 32'h80, 0); chk(q[15:0], calc(16'h2000, gm[0], zm[0]));
    $display("test clock enable done");
    // unmapped address reads zero
    acc(1'b0, 32'hA0, 0); chk(q[15:0], 16'h0000);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule
